// ### logic/ccsr_pkg.sv
// Purpose: shared constants and types of the CPU control/status register block
// Assumes: one core clock, synchronous active-high reset
// Notes: status word halves are addressed by the datapath, not by a bus
package ccsr_pkg;

    // ****************************************
    // Widths and reset values
    // ****************************************
    localparam int PC_WIDTH = 20;
    localparam int PC_LOW_WIDTH = 16;
    localparam logic [3:0] PC_HIGH_RESET = 4'h0;
    localparam logic [7:0] STATUS_HIGH_RESET = 8'h00;
    localparam logic [7:0] STATUS_LOW_RESET = 8'h00;

    // ****************************************
    // Field positions
    // ****************************************
    localparam int HIGH_USER_BIT = 7;
    localparam int HIGH_BANK_MSB = 6;
    localparam int HIGH_BANK_LSB = 4;
    localparam int LOW_SIGN_BIT = 7;
    localparam int LOW_ZERO_BIT = 6;
    localparam int LOW_RSS_BIT = 5;
    localparam int LOW_AUX_BIT = 4;
    localparam int LOW_IE_BIT = 3;
    localparam int LOW_PV_BIT = 2;
    localparam int LOW_FIXED0_BIT = 1;
    localparam int LOW_CARRY_BIT = 0;
    // Writable bits of each half; the rest read as zero
    localparam logic [7:0] HIGH_WRITE_MASK = 8'hf0;
    localparam logic [7:0] LOW_WRITE_MASK = 8'hfd;

    // ****************************************
    // Register numbers behind A, X, B, C, AX, BC
    // ****************************************
    localparam logic [2:0] MAP0_A = 3'h1;
    localparam logic [2:0] MAP0_X = 3'h0;
    localparam logic [2:0] MAP0_B = 3'h3;
    localparam logic [2:0] MAP0_C = 3'h2;
    localparam logic [1:0] MAP0_AX = 2'h0;
    localparam logic [1:0] MAP0_BC = 2'h1;
    localparam logic [2:0] MAP1_A = 3'h5;
    localparam logic [2:0] MAP1_X = 3'h4;
    localparam logic [2:0] MAP1_B = 3'h7;
    localparam logic [2:0] MAP1_C = 3'h6;
    localparam logic [1:0] MAP1_AX = 2'h2;
    localparam logic [1:0] MAP1_BC = 2'h3;

    // ****************************************
    // Types
    // ****************************************
    typedef enum logic [2:0] {
        OP_NONE = 3'b000,
        OP_ARITH = 3'b001,
        OP_LOGIC = 3'b010,
        OP_SHIFT = 3'b011,
        OP_CHECK = 3'b100,
        OP_BITACC = 3'b101
    } ccsr_op_t;

    typedef enum logic [2:0] {
        COND_CARRY = 3'b000,
        COND_NO_CARRY = 3'b001,
        COND_ZERO = 3'b010,
        COND_NOT_ZERO = 3'b011,
        COND_PV = 3'b100,
        COND_NO_PV = 3'b101,
        COND_SIGN = 3'b110,
        COND_NO_SIGN = 3'b111
    } ccsr_cond_t;

    typedef enum logic [0:0] {
        ST_VECTOR = 1'b0,
        ST_RUN = 1'b1
    } ccsr_state_t;

endpackage : ccsr_pkg

// ### logic/ccsr_regs.sv
// Purpose: program counter and status word of the CPU core
// Assumes: the execution datapath drives one-cycle strobes on CORE_CLK
// Notes: flags are computed here from the raw operation results

// How it works
// - 20-bit counter adds instruction length, loads branch target on branch.
// - After reset, low 16 bits fetched from word at address 0, upper cleared.
// - Status word written as two byte halves or one flag at a time.
// - Interrupt accept or break pushes the word; returns pop it back.
// - Context switch saves to the register pair; context returns restore it.
// - Reset clears the whole status word.
// - Bit layout fixed; undefined and must-be-zero bits read as zero.
// - Carry takes carry/borrow, shifted-out bit, or bit-accumulator value.
// - Parity set on even ones; 16-bit shifts look at low byte only.
// - Arithmetic overflow is carry into MSB xor carry out of MSB.
// - Interrupt enable low admits only non-maskable and unmasked macro requests.
// - Enable instruction sets the flag; disable or acknowledge clears it.
// - Aux carry follows carry out of or borrow into bit 3.
// - Zero flag set when result is zero, else cleared.
// - Carry, parity/overflow and zero feed branch condition evaluation.
// - Sign flag copies the result's most significant bit.
// - Three bank bits pick one of eight banks; select-bank writes them.
// - Register-set select remaps A, X, B, C, AX, BC onto upper registers.
module ccsr_regs
    import ccsr_pkg::*;
(
    input wire logic CORE_CLK,
    input wire logic RESET,
    // Reset vector fetch
    output logic VECTOR_READ,
    input wire logic VECTOR_VALID,
    input wire logic [15:0] VECTOR_DATA,
    // Program counter control
    input wire logic PC_ADVANCE,
    input wire logic [2:0] INSTR_LENGTH,
    input wire logic PC_LOAD,
    input wire logic [19:0] PC_TARGET,
    output logic [19:0] PROGRAM_COUNTER,
    // Operation results
    input wire logic [2:0] OP_CLASS,
    input wire logic RESULT_IS_WORD,
    input wire logic [15:0] RESULT,
    input wire logic CARRY_OUT,
    input wire logic CARRY_INTO_MSB,
    input wire logic AUX_CARRY,
    input wire logic SHIFT_OUT,
    input wire logic BIT_ACC_VALUE,
    // Software access to the halves and single flags
    input wire logic HIGH_WRITE,
    input wire logic LOW_WRITE,
    input wire logic [7:0] WRITE_DATA,
    input wire logic BIT_WRITE,
    input wire logic BIT_IN_HIGH,
    input wire logic [2:0] BIT_INDEX,
    input wire logic BIT_VALUE,
    input wire logic SELECT_BANK_INSTR,
    input wire logic [2:0] BANK_NUMBER,
    output logic [7:0] STATUS_WORD_HIGH,
    output logic [7:0] STATUS_WORD_LOW,
    // Save and restore
    input wire logic SAVE_TO_STACK,
    input wire logic SAVE_TO_PAIR,
    input wire logic RESTORE,
    input wire logic [15:0] RESTORE_DATA,
    output logic [15:0] SAVE_DATA,
    output logic STACK_PUSH,
    output logic PAIR_WRITE,
    // Interrupt enable control and acceptance
    input wire logic ENABLE_INTERRUPTS_INSTR,
    input wire logic DISABLE_INTERRUPTS_INSTR,
    input wire logic INTERRUPT_ACK,
    input wire logic NMI_REQUEST,
    input wire logic MACRO_REQUEST_UNMASKED,
    input wire logic MASKABLE_REQUEST,
    output logic ACCEPT_ALLOWED,
    // Branch conditions
    input wire logic [2:0] COND_SELECT,
    output logic COND_TRUE,
    // Register mapping
    output logic [2:0] BANK_SELECT,
    output logic [2:0] REG_A_NUMBER,
    output logic [2:0] REG_X_NUMBER,
    output logic [2:0] REG_B_NUMBER,
    output logic [2:0] REG_C_NUMBER,
    output logic [1:0] PAIR_AX_NUMBER,
    output logic [1:0] PAIR_BC_NUMBER
);

    // ****************************************
    // Helper functions
    // ****************************************
    function automatic logic even_parity(input logic [7:0] value);
        even_parity = ~^value;
    endfunction : even_parity

    function automatic logic [7:0] clean_high(input logic [7:0] value);
        clean_high = value & HIGH_WRITE_MASK;
    endfunction : clean_high

    function automatic logic [7:0] clean_low(input logic [7:0] value);
        clean_low = value & LOW_WRITE_MASK;
    endfunction : clean_low

    // ****************************************
    // Program counter and reset vector
    // ****************************************
    ccsr_state_t state;
    logic [19:0] pc;

    always_ff @(posedge CORE_CLK)
    begin
        if (RESET)
        begin
            state <= ST_VECTOR;
            VECTOR_READ <= 1'b1;
        end
        else if (state == ST_VECTOR && VECTOR_VALID)
        begin
            state <= ST_RUN;
            VECTOR_READ <= 1'b0;
        end
    end

    always_ff @(posedge CORE_CLK)
    begin
        if (RESET)
        begin
            pc <= {PC_HIGH_RESET, 16'h0000};
        end
        else
        begin
            case (state)
                ST_VECTOR:
                begin
                    if (VECTOR_VALID)
                    begin
                        pc <= {PC_HIGH_RESET, VECTOR_DATA};
                    end
                end
                ST_RUN:
                begin
                    if (PC_LOAD)
                    begin
                        pc <= PC_TARGET;
                    end
                    else if (PC_ADVANCE)
                    begin
                        pc <= pc + {17'h00000, INSTR_LENGTH};
                    end
                end
                default:
                begin
                    pc <= pc;
                end
            endcase
        end
    end

    assign PROGRAM_COUNTER = pc;

    // ****************************************
    // Status word next value
    // ****************************************
    logic [7:0] high_half;
    logic [7:0] low_half;
    logic [7:0] next_high;
    logic [7:0] next_low;
    logic res_zero;
    logic res_sign;
    logic res_parity;

    always_comb
    begin
        res_zero = RESULT_IS_WORD ? (RESULT == 16'h0000) : (RESULT[7:0] == 8'h00);
        res_sign = RESULT_IS_WORD ? RESULT[15] : RESULT[7];
        // Word shifts and words alike judge parity on the low byte
        res_parity = even_parity(RESULT[7:0]);
        next_high = high_half;
        next_low = low_half;
        case (ccsr_op_t'(OP_CLASS))
            OP_ARITH:
            begin
                next_low[LOW_CARRY_BIT] = CARRY_OUT;
                next_low[LOW_PV_BIT] = CARRY_OUT ^ CARRY_INTO_MSB;
                next_low[LOW_AUX_BIT] = AUX_CARRY;
                next_low[LOW_ZERO_BIT] = res_zero;
                next_low[LOW_SIGN_BIT] = res_sign;
            end
            OP_LOGIC, OP_CHECK:
            begin
                next_low[LOW_PV_BIT] = res_parity;
                next_low[LOW_ZERO_BIT] = res_zero;
                next_low[LOW_SIGN_BIT] = res_sign;
            end
            OP_SHIFT:
            begin
                next_low[LOW_CARRY_BIT] = SHIFT_OUT;
                next_low[LOW_PV_BIT] = res_parity;
                next_low[LOW_ZERO_BIT] = res_zero;
                next_low[LOW_SIGN_BIT] = res_sign;
            end
            OP_BITACC:
            begin
                next_low[LOW_CARRY_BIT] = BIT_ACC_VALUE;
            end
            default:
            begin
                next_low = low_half;
            end
        endcase
        if (BIT_WRITE)
        begin
            if (BIT_IN_HIGH)
            begin
                next_high[BIT_INDEX] = BIT_VALUE;
            end
            else
            begin
                next_low[BIT_INDEX] = BIT_VALUE;
            end
        end
        if (HIGH_WRITE)
        begin
            next_high = WRITE_DATA;
        end
        if (LOW_WRITE)
        begin
            next_low = WRITE_DATA;
        end
        if (SELECT_BANK_INSTR)
        begin
            next_high[HIGH_BANK_MSB:HIGH_BANK_LSB] = BANK_NUMBER;
        end
        if (RESTORE)
        begin
            next_high = RESTORE_DATA[15:8];
            next_low = RESTORE_DATA[7:0];
        end
        if (ENABLE_INTERRUPTS_INSTR)
        begin
            next_low[LOW_IE_BIT] = 1'b1;
        end
        if (DISABLE_INTERRUPTS_INSTR || INTERRUPT_ACK)
        begin
            next_low[LOW_IE_BIT] = 1'b0;
        end
        // undefined and fixed bits read as zero
        next_high = clean_high(next_high);
        next_low = clean_low(next_low);
    end

    // ****************************************
    // Status word storage
    // ****************************************
    always_ff @(posedge CORE_CLK)
    begin
        if (RESET)
        begin
            high_half <= STATUS_HIGH_RESET;
            low_half <= STATUS_LOW_RESET;
        end
        else
        begin
            high_half <= next_high;
            low_half <= next_low;
        end
    end

    assign STATUS_WORD_HIGH = high_half;
    assign STATUS_WORD_LOW = low_half;
    assign BANK_SELECT = high_half[HIGH_BANK_MSB:HIGH_BANK_LSB];

    // ****************************************
    // Save path
    // ****************************************
    // The value saved is the word before this cycle's changes, so an
    // acknowledge clearing the enable flag saves the old enable state.
    always_ff @(posedge CORE_CLK)
    begin
        if (RESET)
        begin
            SAVE_DATA <= 16'h0000;
            STACK_PUSH <= 1'b0;
            PAIR_WRITE <= 1'b0;
        end
        else
        begin
            STACK_PUSH <= SAVE_TO_STACK;
            PAIR_WRITE <= SAVE_TO_PAIR;
            if (SAVE_TO_STACK || SAVE_TO_PAIR)
            begin
                SAVE_DATA <= {high_half, low_half};
            end
        end
    end

    // ****************************************
    // Interrupt acceptance and conditions
    // ****************************************
    always_ff @(posedge CORE_CLK)
    begin
        if (RESET)
        begin
            ACCEPT_ALLOWED <= 1'b0;
        end
        else
        begin
            ACCEPT_ALLOWED <= NMI_REQUEST || MACRO_REQUEST_UNMASKED
                || (next_low[LOW_IE_BIT] && MASKABLE_REQUEST);
        end
    end

    always_ff @(posedge CORE_CLK)
    begin
        if (RESET)
        begin
            COND_TRUE <= 1'b0;
        end
        else
        begin
            case (ccsr_cond_t'(COND_SELECT))
                COND_CARRY: COND_TRUE <= next_low[LOW_CARRY_BIT];
                COND_NO_CARRY: COND_TRUE <= ~next_low[LOW_CARRY_BIT];
                COND_ZERO: COND_TRUE <= next_low[LOW_ZERO_BIT];
                COND_NOT_ZERO: COND_TRUE <= ~next_low[LOW_ZERO_BIT];
                COND_PV: COND_TRUE <= next_low[LOW_PV_BIT];
                COND_NO_PV: COND_TRUE <= ~next_low[LOW_PV_BIT];
                COND_SIGN: COND_TRUE <= next_low[LOW_SIGN_BIT];
                COND_NO_SIGN: COND_TRUE <= ~next_low[LOW_SIGN_BIT];
                default: COND_TRUE <= 1'b0;
            endcase
        end
    end

    // ****************************************
    // Register set mapping
    // ****************************************
    // Legacy mapping only; software is expected to leave it at zero
    always_ff @(posedge CORE_CLK)
    begin
        if (RESET || !next_low[LOW_RSS_BIT])
        begin
            REG_A_NUMBER <= MAP0_A;
            REG_X_NUMBER <= MAP0_X;
            REG_B_NUMBER <= MAP0_B;
            REG_C_NUMBER <= MAP0_C;
            PAIR_AX_NUMBER <= MAP0_AX;
            PAIR_BC_NUMBER <= MAP0_BC;
        end
        else
        begin
            REG_A_NUMBER <= MAP1_A;
            REG_X_NUMBER <= MAP1_X;
            REG_B_NUMBER <= MAP1_B;
            REG_C_NUMBER <= MAP1_C;
            PAIR_AX_NUMBER <= MAP1_AX;
            PAIR_BC_NUMBER <= MAP1_BC;
        end
    end

endmodule : ccsr_regs

// ### verif/ccsr_regs_sva.sv
// Purpose: port-level checker for the control/status register block
// Assumes: one clock, synchronous active-high reset
// Notes: attached to the design by the bind at the foot of this file
module ccsr_regs_sva
(
    input wire logic CORE_CLK,
    input wire logic RESET,
    input wire logic VECTOR_READ,
    input wire logic VECTOR_VALID,
    input wire logic [15:0] VECTOR_DATA,
    input wire logic PC_ADVANCE,
    input wire logic [2:0] INSTR_LENGTH,
    input wire logic PC_LOAD,
    input wire logic [19:0] PC_TARGET,
    input wire logic [19:0] PROGRAM_COUNTER,
    input wire logic [7:0] STATUS_WORD_HIGH,
    input wire logic [7:0] STATUS_WORD_LOW,
    input wire logic SAVE_TO_STACK,
    input wire logic SAVE_TO_PAIR,
    input wire logic [15:0] SAVE_DATA,
    input wire logic STACK_PUSH,
    input wire logic PAIR_WRITE,
    input wire logic ENABLE_INTERRUPTS_INSTR,
    input wire logic DISABLE_INTERRUPTS_INSTR,
    input wire logic INTERRUPT_ACK,
    input wire logic NMI_REQUEST,
    input wire logic MACRO_REQUEST_UNMASKED,
    input wire logic ACCEPT_ALLOWED,
    input wire logic [2:0] BANK_SELECT
);
    timeunit 1ns;
    timeprecision 1ns;

    // ****************************************
    // Properties
    // ****************************************
    default clocking cb @(posedge CORE_CLK);
    endclocking
    default disable iff (RESET);

    a_vector_load:
        assert property (VECTOR_READ && VECTOR_VALID |=> !VECTOR_READ
            && PROGRAM_COUNTER == {4'h0, $past(VECTOR_DATA)}) else $error("vector load");
    a_pc_advance:
        assert property (!VECTOR_READ && PC_ADVANCE && !PC_LOAD |=> PROGRAM_COUNTER
            == $past(PROGRAM_COUNTER) + {17'h0, $past(INSTR_LENGTH)}) else $error("pc step");
    a_pc_load:
        assert property (!VECTOR_READ && PC_LOAD |=> PROGRAM_COUNTER == $past(PC_TARGET))
            else $error("pc load");
    a_fixed_zero:
        assert property (STATUS_WORD_HIGH[3:0] == 4'h0 && !STATUS_WORD_LOW[1])
            else $error("fixed bits");
    a_stack_save:
        assert property (SAVE_TO_STACK |=> STACK_PUSH
            && SAVE_DATA == {$past(STATUS_WORD_HIGH), $past(STATUS_WORD_LOW)})
            else $error("stack save");
    a_pair_save:
        assert property (SAVE_TO_PAIR |=> PAIR_WRITE
            && SAVE_DATA == {$past(STATUS_WORD_HIGH), $past(STATUS_WORD_LOW)})
            else $error("pair save");
    a_ie_clear:
        assert property (DISABLE_INTERRUPTS_INSTR || INTERRUPT_ACK |=> !STATUS_WORD_LOW[3])
            else $error("ie clear");
    a_ie_set:
        assert property (ENABLE_INTERRUPTS_INSTR && !DISABLE_INTERRUPTS_INSTR
            && !INTERRUPT_ACK |=> STATUS_WORD_LOW[3]) else $error("ie set");
    a_bank_follow:
        assert property (BANK_SELECT == STATUS_WORD_HIGH[6:4]) else $error("bank out");
    a_nmi_accept:
        assert property (NMI_REQUEST || MACRO_REQUEST_UNMASKED |=> ACCEPT_ALLOWED)
            else $error("accept");
endmodule : ccsr_regs_sva

bind ccsr_regs ccsr_regs_sva u_sva (.*);

// ### verif/ccsr_regs_tb.sv
// Purpose: directed bench for the control/status register block
// Assumes: inputs change by non-blocking assignment on the rising edge
// Notes: results are compared 1 ns after the edge that takes them
module ccsr_regs_tb
    import ccsr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    logic CORE_CLK, RESET, VECTOR_VALID, PC_ADVANCE, PC_LOAD, RESULT_IS_WORD;
    logic CARRY_OUT, CARRY_INTO_MSB, AUX_CARRY, SHIFT_OUT, BIT_ACC_VALUE, BIT_VALUE;
    logic HIGH_WRITE, LOW_WRITE, BIT_WRITE, BIT_IN_HIGH, SELECT_BANK_INSTR, RESTORE;
    logic SAVE_TO_STACK, SAVE_TO_PAIR, ENABLE_INTERRUPTS_INSTR, DISABLE_INTERRUPTS_INSTR;
    logic INTERRUPT_ACK, NMI_REQUEST, MACRO_REQUEST_UNMASKED, MASKABLE_REQUEST;
    logic VECTOR_READ, STACK_PUSH, PAIR_WRITE, ACCEPT_ALLOWED, COND_TRUE;
    logic [15:0] VECTOR_DATA, RESULT, RESTORE_DATA, SAVE_DATA;
    logic [19:0] PC_TARGET, PROGRAM_COUNTER;
    logic [7:0] WRITE_DATA, STATUS_WORD_HIGH, STATUS_WORD_LOW;
    logic [2:0] INSTR_LENGTH, OP_CLASS, BIT_INDEX, BANK_NUMBER, COND_SELECT, BANK_SELECT;
    logic [2:0] REG_A_NUMBER, REG_X_NUMBER, REG_B_NUMBER, REG_C_NUMBER;
    logic [1:0] PAIR_AX_NUMBER, PAIR_BC_NUMBER;
    localparam logic [7:0] COND_EXP = 8'h95;
    int fails = 0;
    int n_tests = 0;

    ccsr_regs DUT (.*);

    always #50 CORE_CLK = ~CORE_CLK;

    // ****************************************
    // Tasks
    // ****************************************
    task automatic chk(input logic [19:0] got, input logic [19:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            fails++;
            $display("MISMATCH at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic end_of_test;
        $display("Comparisons %0d, mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : end_of_test

    // Drops every strobe at the edge that takes it, then lets outputs settle
    task automatic nxt;
        @(posedge CORE_CLK);
        {VECTOR_VALID, PC_ADVANCE, PC_LOAD, HIGH_WRITE, LOW_WRITE, BIT_WRITE} <= '0;
        {SELECT_BANK_INSTR, SAVE_TO_STACK, SAVE_TO_PAIR, RESTORE} <= '0;
        {ENABLE_INTERRUPTS_INSTR, DISABLE_INTERRUPTS_INSTR, INTERRUPT_ACK} <= '0;
        OP_CLASS <= OP_NONE;
        #1;
    endtask : nxt

    task automatic op(input logic [2:0] cls, input logic wd, input logic [15:0] r,
        input logic [4:0] f, input logic [7:0] exp);
        @(posedge CORE_CLK);
        OP_CLASS <= cls;
        RESULT_IS_WORD <= wd;
        RESULT <= r;
        {CARRY_OUT, CARRY_INTO_MSB, AUX_CARRY, SHIFT_OUT, BIT_ACC_VALUE} <= f;
        nxt;
        chk(STATUS_WORD_LOW, exp);
    endtask : op

    task automatic wr(input logic hi, input logic [7:0] d, input logic [15:0] exp);
        @(posedge CORE_CLK);
        HIGH_WRITE <= hi;
        LOW_WRITE <= !hi;
        WRITE_DATA <= d;
        nxt;
        chk({STATUS_WORD_HIGH, STATUS_WORD_LOW}, exp);
    endtask : wr

    task automatic bw(input logic hi, input logic [2:0] ix, input logic v,
        input logic [15:0] exp);
        @(posedge CORE_CLK);
        BIT_WRITE <= 1'b1;
        BIT_IN_HIGH <= hi;
        BIT_INDEX <= ix;
        BIT_VALUE <= v;
        nxt;
        chk({STATUS_WORD_HIGH, STATUS_WORD_LOW}, exp);
    endtask : bw

    task automatic ie(input logic [2:0] eda, input logic [7:0] exp);
        @(posedge CORE_CLK);
        {ENABLE_INTERRUPTS_INSTR, DISABLE_INTERRUPTS_INSTR, INTERRUPT_ACK} <= eda;
        nxt;
        chk(STATUS_WORD_LOW, exp);
    endtask : ie

    task automatic acc(input logic [2:0] lv, input logic exp);
        @(posedge CORE_CLK);
        {NMI_REQUEST, MACRO_REQUEST_UNMASKED, MASKABLE_REQUEST} <= lv;
        nxt;
        chk(ACCEPT_ALLOWED, exp);
    endtask : acc

    // ****************************************
    // Sequence
    // ****************************************
    initial
    begin
        repeat (2000) @(posedge CORE_CLK);
        fails++;
        end_of_test();
    end

    initial
    begin
        CORE_CLK = 1'b0;
        RESET = 1'b1;
        {VECTOR_VALID, PC_ADVANCE, PC_LOAD, RESULT_IS_WORD, CARRY_OUT, CARRY_INTO_MSB,
            AUX_CARRY, SHIFT_OUT, BIT_ACC_VALUE, BIT_VALUE, HIGH_WRITE, LOW_WRITE,
            BIT_WRITE, BIT_IN_HIGH, SELECT_BANK_INSTR, RESTORE, SAVE_TO_STACK,
            SAVE_TO_PAIR, ENABLE_INTERRUPTS_INSTR, DISABLE_INTERRUPTS_INSTR,
            INTERRUPT_ACK, NMI_REQUEST, MACRO_REQUEST_UNMASKED, MASKABLE_REQUEST,
            VECTOR_DATA, RESULT, RESTORE_DATA, PC_TARGET, WRITE_DATA, INSTR_LENGTH,
            OP_CLASS, BIT_INDEX, BANK_NUMBER, COND_SELECT} = '0;
        repeat (8) @(posedge CORE_CLK);
        RESET <= 1'b0;
        #1;
        chk({STATUS_WORD_HIGH, STATUS_WORD_LOW}, 16'h0000);
        // Counting must wait for the vector
        @(posedge CORE_CLK);
        PC_ADVANCE <= 1'b1;
        INSTR_LENGTH <= 3'h5;
        nxt;
        chk({VECTOR_READ, PROGRAM_COUNTER}, {1'b1, 20'h00000});
        @(posedge CORE_CLK);
        VECTOR_VALID <= 1'b1;
        VECTOR_DATA <= 16'hbeef;
        nxt;
        chk({VECTOR_READ, PROGRAM_COUNTER}, {1'b0, 20'h0beef});
        @(posedge CORE_CLK);
        VECTOR_VALID <= 1'b1;
        VECTOR_DATA <= 16'h1234;
        nxt;
        chk(PROGRAM_COUNTER, 20'h0beef);
        @(posedge CORE_CLK);
        PC_ADVANCE <= 1'b1;
        INSTR_LENGTH <= 3'h3;
        @(posedge CORE_CLK);
        INSTR_LENGTH <= 3'h7;
        nxt;
        chk(PROGRAM_COUNTER, 20'h0bef9);
        @(posedge CORE_CLK);
        PC_LOAD <= 1'b1;
        PC_TARGET <= 20'hffffe;
        PC_ADVANCE <= 1'b1;
        nxt;
        chk(PROGRAM_COUNTER, 20'hffffe);
        @(posedge CORE_CLK);
        PC_ADVANCE <= 1'b1;
        INSTR_LENGTH <= 3'h4;
        nxt;
        chk(PROGRAM_COUNTER, 20'h00002);
        op(OP_ARITH, 1'b0, 16'h00e1, 5'b01100, 8'h94);
        op(OP_ARITH, 1'b0, 16'h0000, 5'b11000, 8'h41);
        op(OP_LOGIC, 1'b0, 16'h0103, 5'b00000, 8'h05);
        op(OP_SHIFT, 1'b1, 16'h8007, 5'b00000, 8'h80);
        op(OP_BITACC, 1'b0, 16'h0000, 5'b00001, 8'h81);
        op(OP_CHECK, 1'b0, 16'hff00, 5'b00000, 8'h45);
        for (int i = 0; i < 8; i++)
        begin
            @(posedge CORE_CLK);
            COND_SELECT <= 3'(i);
            nxt;
            chk(COND_TRUE, COND_EXP[i]);
        end
        wr(1'b1, 8'hff, 16'hf045);
        wr(1'b0, 8'hff, 16'hf0fd);
        bw(1'b0, 3'h1, 1'b1, 16'hf0fd);
        bw(1'b1, 3'h2, 1'b1, 16'hf0fd);
        bw(1'b1, 3'h7, 1'b0, 16'h70fd);
        for (int i = 0; i < 8; i++)
        begin
            @(posedge CORE_CLK);
            SELECT_BANK_INSTR <= 1'b1;
            BANK_NUMBER <= 3'(i);
            nxt;
            chk({STATUS_WORD_HIGH, BANK_SELECT}, {1'b0, 3'(i), 4'h0, 3'(i)});
        end
        chk({REG_A_NUMBER, REG_X_NUMBER, REG_B_NUMBER, REG_C_NUMBER, PAIR_AX_NUMBER,
            PAIR_BC_NUMBER}, 16'hb3eb);
        // Register-set select back to zero, as software is expected to keep it
        bw(1'b0, 3'h5, 1'b0, 16'h70dd);
        chk({REG_A_NUMBER, REG_X_NUMBER, REG_B_NUMBER, REG_C_NUMBER, PAIR_AX_NUMBER,
            PAIR_BC_NUMBER}, 16'h21a1);
        ie(3'b010, 8'hd5);
        ie(3'b100, 8'hdd);
        ie(3'b110, 8'hd5);
        ie(3'b101, 8'hd5);
        acc(3'b001, 1'b0);
        acc(3'b100, 1'b1);
        acc(3'b010, 1'b1);
        ie(3'b100, 8'hdd);
        acc(3'b001, 1'b1);
        ie(3'b001, 8'hd5);
        ie(3'b100, 8'hdd);
        // Saved word must be the value before a same-cycle write
        @(posedge CORE_CLK);
        SAVE_TO_STACK <= 1'b1;
        LOW_WRITE <= 1'b1;
        WRITE_DATA <= 8'h00;
        nxt;
        chk({STACK_PUSH, PAIR_WRITE, SAVE_DATA}, {2'b10, 16'h70dd});
        @(posedge CORE_CLK);
        SAVE_TO_PAIR <= 1'b1;
        nxt;
        chk({STACK_PUSH, PAIR_WRITE, SAVE_DATA}, {2'b01, 16'h7000});
        @(posedge CORE_CLK);
        RESTORE <= 1'b1;
        RESTORE_DATA <= 16'habff;
        nxt;
        chk({STATUS_WORD_HIGH, STATUS_WORD_LOW}, 16'ha0fd);
        @(posedge CORE_CLK);
        RESET <= 1'b1;
        @(posedge CORE_CLK);
        RESET <= 1'b0;
        #1;
        chk({STATUS_WORD_HIGH, STATUS_WORD_LOW}, 16'h0000);
        chk({VECTOR_READ, PROGRAM_COUNTER}, {1'b1, 20'h00000});
        end_of_test();
    end
endmodule : ccsr_regs_tb
